// file: design/spindle_seq.sv
// spindle start-up sequencer, serial register port, status and revision readback
`timescale 1ns/1ns
module spindle_seq
   import spindle_seq_pkg::*;
#(
   parameter int unsigned ALIGN_CYCLES = ALIGN_CYCLES_DEF,
   parameter int unsigned ADVANCE_CYCLES = ADVANCE_CYCLES_DEF,
   parameter int unsigned RESYNC_CYCLES = RESYNC_CYCLES_DEF,
   parameter logic [7:0] REVISION_CODE = 8'h5a // arbitrary value
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic sden_in,
   input wire logic sclk_in,
   input wire logic sdata_in,
   output logic sdata_out,
   output logic sdata_oe_out,
   input wire logic overtemp_shutdown_in,
   input wire logic overtemp_warn_in,
   input wire logic bemf_lost_in,
   input wire logic fault_in,
   input wire logic bemf_mask_n_in,
   input wire logic speed_locked_in,
   input wire logic zero_cross_in,
   input wire logic actuator_chopping_mode_in,
   output logic [2:0] phase_out,
   output logic spindle_tristate_out,
   output logic spindle_brake_out,
   output logic actuator_tristate_out,
   output logic retract_start_out,
   output logic standby_out,
   output logic actuator_fast_slew_out,
   output logic actuator_force_high_out,
   output logic spindle_slow_slew_out,
   output logic zero_cross_toggle_out
);
   // ==========================================================
   // input synchronisers
   logic [10:0] pins_s;
   logic sden_s, sclk_s, sdata_s, hot_s, warn_s, lost_s, fault_s, mask_s, lock_s, zc_s, chop_s;

   pin_sync #(.WIDTH(11)) u_sync (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .async_in({sden_in, sclk_in, sdata_in, overtemp_shutdown_in, overtemp_warn_in,
                 bemf_lost_in, fault_in, bemf_mask_n_in, speed_locked_in, zero_cross_in,
                 actuator_chopping_mode_in}),
      .sync_out(pins_s)
   );
   assign {sden_s, sclk_s, sdata_s, hot_s, warn_s, lost_s, fault_s, mask_s, lock_s, zc_s,
           chop_s} = pins_s;

   // ==========================================================
   // serial frame receiver and read shifter
   logic sclk_prev_q, zc_prev_q, hot_prev_q;
   logic [4:0] bit_cnt_q;
   logic [15:0] shift_q;
   logic [7:0] rd_shift_q;
   logic sclk_rise_w, sclk_fall_w;
   logic [15:0] frame_w;
   logic wr_fire_w, rd_start_w;
   logic [7:0] rd_data_w;

   assign sclk_rise_w = sden_s & sclk_s & ~sclk_prev_q;
   assign sclk_fall_w = sden_s & ~sclk_s & sclk_prev_q;
   assign frame_w = {sdata_s, shift_q[15:1]};
   // writes land on the sixteenth rising edge, never during shutdown standby
   assign wr_fire_w = sclk_rise_w && (bit_cnt_q == FRAME_BITS - 5'h1) && !frame_w[0] &&
                      !standby_out; // R6
   assign rd_start_w = sclk_fall_w && (bit_cnt_q == ADDR_BITS) && shift_q[8];

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bit_cnt_q <= '0;
         shift_q <= '0;
      end else if (!sden_s) begin
         bit_cnt_q <= '0;
      end else if (sclk_rise_w && bit_cnt_q != FRAME_BITS) begin
         bit_cnt_q <= bit_cnt_q + 5'h1;
         shift_q <= frame_w;
      end
   end

   // read data go out lsb first after the eighth falling edge
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rd_shift_q <= '0;
         sdata_out <= 1'b0;
         sdata_oe_out <= 1'b0;
      end else if (!sden_s) begin
         sdata_oe_out <= 1'b0;
      end else if (rd_start_w) begin
         rd_shift_q <= {1'b0, rd_data_w[7:1]};
         sdata_out <= rd_data_w[0];
         sdata_oe_out <= 1'b1;
      end else if (sclk_fall_w && sdata_oe_out) begin
         rd_shift_q <= {1'b0, rd_shift_q[7:1]};
         sdata_out <= rd_shift_q[0];
      end
   end

   // ==========================================================
   // write-only registers
   logic [7:0] spin_ctrl_q, sys_ctrl_q, act_slew_q;
   logic [6:0] wr_addr_w;
   logic [7:0] wr_data_w;
   logic step_req_w;

   assign wr_addr_w = frame_w[7:1];
   assign wr_data_w = frame_w[15:8];
   // only the zero-to-one change of the step bit commands a step
   assign step_req_w = wr_fire_w && (wr_addr_w == ADDR_SPINDLE_CTRL) &&
                       wr_data_w[COMMUTATION_STEP_BIT] &&
                       !spin_ctrl_q[COMMUTATION_STEP_BIT]; // R19

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         spin_ctrl_q <= REG_RESET;
         sys_ctrl_q <= REG_RESET;
         act_slew_q <= REG_RESET;
      end else if (wr_fire_w) begin
         if (wr_addr_w == ADDR_SPINDLE_CTRL) spin_ctrl_q <= wr_data_w;
         if (wr_addr_w == ADDR_SYSTEM_CTRL) sys_ctrl_q <= wr_data_w;
         if (wr_addr_w == ADDR_ACTUATOR_SLEW) act_slew_q <= wr_data_w;
      end
   end

   // ==========================================================
   // readable registers: status and revision only
   seq_state_e state_q, state_d;
   logic [7:0] status_w;

   assign status_w = {state_q != ST_GO, state_q != ST_ALIGN, // R12
                      lock_s, // R11
                      mask_s, // R10
                      fault_s, // R9
                      !lost_s, // R8
                      !warn_s, // R7
                      !hot_s}; // R5
   assign rd_data_w = (shift_q[15:9] == ADDR_HEALTH_STATUS) ? status_w : // R4
                      (shift_q[15:9] == ADDR_REVISION) ? REVISION_CODE : 8'h00; // R13

   // ==========================================================
   // start-up sequencer
   logic [CNT_W-1:0] cnt_q, limit_w;
   logic dbl_w, spin_ok_w, auto_w, cnt_done_w, step_one_w, step_two_w;

   assign dbl_w = sys_ctrl_q[DOUBLE_TIME_BIT];
   assign auto_w = spin_ctrl_q[AUTO_SPINUP_BIT];
   assign spin_ok_w = spin_ctrl_q[SPIN_CMD_BIT] && spin_ctrl_q[SPIN_OUT_EN_BIT] &&
                      !standby_out; // R23
   assign limit_w = (state_q == ST_RESYNC) ? CNT_W'(RESYNC_CYCLES - 1) :
                    (state_q == ST_ALIGN) ? CNT_W'((ALIGN_CYCLES << dbl_w) - 1) : // R17 R18
                    CNT_W'((ADVANCE_CYCLES << dbl_w) - 1); // R17 R18
   assign cnt_done_w = (cnt_q == limit_w);

   // next state of the align-and-go walk
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: if (spin_ok_w) state_d = auto_w ? ST_RESYNC : ST_EXT; // R14
         ST_EXT: if (auto_w) state_d = ST_GO;
         ST_RESYNC: if (cnt_done_w) state_d = ST_ALIGN; // R14
         ST_ALIGN: if (cnt_done_w) state_d = ST_ADVANCE; // R16
         ST_ADVANCE: if (cnt_done_w) state_d = ST_GO; // R16
         ST_GO: if (!auto_w) state_d = ST_EXT;
      endcase
      if (!spin_ok_w) state_d = ST_IDLE; // R23
   end

   // phase step sources: double step at align and advance interval ends, single on crossings or host
   assign step_two_w = (state_q == ST_ALIGN || state_q == ST_ADVANCE) && cnt_done_w &&
                       spin_ok_w; // R16
   assign step_one_w = ((state_q == ST_GO) && zc_s && !zc_prev_q && spin_ok_w) || // R16
                       ((state_q == ST_EXT || state_q == ST_IDLE) && step_req_w && !auto_w); // R19

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= (state_d != state_q || cnt_done_w) ? '0 : cnt_q + CNT_W'(1);
      end
   end

   phase_counter u_phase (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .clear_in(spin_ctrl_q[COMMUTATION_PHASE_RESET_BIT]), // R24
      .step_one_in(step_one_w),
      .step_two_in(step_two_w),
      .phase_out(phase_out)
   );

   // ==========================================================
   // protection, edge trackers and zero-cross toggle
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sclk_prev_q <= 1'b0;
         zc_prev_q <= 1'b0;
         hot_prev_q <= 1'b0;
         zero_cross_toggle_out <= 1'b0;
         retract_start_out <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
         zc_prev_q <= zc_s;
         hot_prev_q <= hot_s;
         if (zc_s && !zc_prev_q) zero_cross_toggle_out <= !zero_cross_toggle_out; // R20
         retract_start_out <= hot_s && !hot_prev_q; // R5
      end
   end

   assign standby_out = hot_s; // R6
   assign spindle_tristate_out = hot_s || lost_s || !spin_ctrl_q[SPIN_OUT_EN_BIT]; // R5 R8
   assign actuator_tristate_out = lost_s || hot_s; // R8
   assign spindle_brake_out = !spin_ctrl_q[SPIN_CMD_BIT] && !hot_s; // R23
   assign actuator_fast_slew_out = act_slew_q[ACT_FAST_SLEW_BIT]; // R1
   assign actuator_force_high_out = act_slew_q[ACT_FORCE_HIGH_BIT] && chop_s; // R2
   assign spindle_slow_slew_out = act_slew_q[SPIN_SLOW_SLEW_BIT]; // R3

   // ==========================================================
   // checks: protection, standby and actuator force-high gating
   write_blocked_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R6
      standby_out |-> !wr_fire_w) else $error("write accepted in standby");
   standby_frozen_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R6
      standby_out |=> $stable(spin_ctrl_q) && $stable(sys_ctrl_q) && $stable(act_slew_q))
      else $error("register changed in standby");
   shutdown_off_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R5
      hot_s |-> spindle_tristate_out && actuator_tristate_out)
      else $error("outputs driven during shutdown");
   retract_pulse_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R5
      hot_s && !hot_prev_q |=> retract_start_out) else $error("retract not started");
   retract_once_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R5
      retract_start_out |=> !retract_start_out) else $error("retract pulse too long");
   shutdown_idle_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R6
      hot_s |=> state_q == ST_IDLE) else $error("sequencer ran in standby");
   bemf_lost_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R8
      lost_s |-> spindle_tristate_out && actuator_tristate_out && !status_w[2])
      else $error("bemf loss not handled");
   force_high_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R2
      actuator_force_high_out |-> chop_s && act_slew_q[ACT_FORCE_HIGH_BIT])
      else $error("force high outside chopping");

   // checks: read path of the status, revision and write-only registers
   read_drive_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R4
      rd_start_w |=> sdata_oe_out && sdata_out == $past(rd_data_w[0]))
      else $error("read data not driven");
   write_only_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R4
      rd_start_w && shift_q[15:9] != ADDR_HEALTH_STATUS && shift_q[15:9] != ADDR_REVISION |=>
      !sdata_out && rd_shift_q == 8'h00) else $error("write-only register read back");
   revision_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R13
      rd_start_w && shift_q[15:9] == ADDR_REVISION |=>
      {rd_shift_q[6:0], sdata_out} == REVISION_CODE) else $error("revision code wrong");
   mask_live_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R9 R10 R11
      rd_start_w && shift_q[15:9] == ADDR_HEALTH_STATUS |=>
      rd_shift_q[4:2] == $past({lock_s, mask_s, fault_s}) && sdata_out == $past(!hot_s))
      else $error("status bits not live");
   align_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R12
      rd_start_w && shift_q[15:9] == ADDR_HEALTH_STATUS |=>
      rd_shift_q[6:5] == {$past(state_q != ST_GO), $past(state_q != ST_ALIGN)})
      else $error("align or go flag wrong");

   // checks: start-up walk and interval lengths
   resync_entry_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R14
      state_q == ST_IDLE && spin_ok_w && auto_w |=> state_q == ST_RESYNC && cnt_q == '0)
      else $error("resync wait not entered");
   resync_length_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R14
      state_q == ST_RESYNC && state_d == ST_ALIGN |-> cnt_q == CNT_W'(RESYNC_CYCLES - 1))
      else $error("resync wait length wrong");
   align_length_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R17 R18
      state_q == ST_ALIGN && state_d == ST_ADVANCE |->
      cnt_q == CNT_W'(dbl_w ? 2 * ALIGN_CYCLES - 1 : ALIGN_CYCLES - 1))
      else $error("align interval length wrong");
   advance_length_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R17 R18
      state_q == ST_ADVANCE && state_d == ST_GO |->
      cnt_q == CNT_W'(dbl_w ? 2 * ADVANCE_CYCLES - 1 : ADVANCE_CYCLES - 1))
      else $error("advance interval length wrong");
   spin_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R23
      !spin_ctrl_q[SPIN_CMD_BIT] |=> state_q == ST_IDLE) else $error("spin clear ignored");

   // checks: phase stepping
   double_step_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R16
      step_two_w && !spin_ctrl_q[COMMUTATION_PHASE_RESET_BIT] |=>
      phase_out == ($past(phase_out) >= 3'h4 ? $past(phase_out) - 3'h4 :
                    $past(phase_out) + 3'h2)) else $error("double step wrong");
   go_step_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R16
      state_q == ST_GO && zc_s && !zc_prev_q && spin_ok_w &&
      !spin_ctrl_q[COMMUTATION_PHASE_RESET_BIT] |=>
      phase_out == ($past(phase_out) == PHASE_LAST ? PHASE_ONE : $past(phase_out) + 3'h1))
      else $error("go step missed");
   manual_step_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R19
      step_req_w && state_q == ST_EXT && !auto_w &&
      !spin_ctrl_q[COMMUTATION_PHASE_RESET_BIT] |=>
      phase_out == ($past(phase_out) == PHASE_LAST ? PHASE_ONE : $past(phase_out) + 3'h1))
      else $error("manual step wrong");
   auto_no_step_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R19
      auto_w && state_q != ST_GO && !step_two_w &&
      !spin_ctrl_q[COMMUTATION_PHASE_RESET_BIT] |=> phase_out == $past(phase_out))
      else $error("step taken with auto spin-up set");
   toggle_zc_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R20
      zc_s && !zc_prev_q |=> zero_cross_toggle_out != $past(zero_cross_toggle_out))
      else $error("zero-cross toggle missed");
   phase_reset_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // R24
      spin_ctrl_q[COMMUTATION_PHASE_RESET_BIT] |=> phase_out == PHASE_ONE)
      else $error("phase reset ignored");
endmodule // spindle_seq

// file: design/spindle_seq_pkg.sv
// constants, register map and field positions for the spindle start-up sequencer
// Behaviour
// (R1) actuator control bit0 picks fast or slow chopping slew
// (R2) actuator control bit1 forces outputs high in chopping
// (R3) actuator control bit3 picks commutation slew, 2 or 30
// (R4) only status and revision registers read; others write-only
// (R5) shutdown flag low tristates spindle, starts actuator retract
// (R6) shutdown holds everything in standby except serial reads
// (R7) warning flag low while hot, no other action
// (R8) back-emf lost: flag low, spindle and actuator tristated
// (R9) fault flag mirrors deceleration or fast toggle only
// (R10) status bit4 shows live back-emf mask signal
// (R11) status bit5 high while speed is locked
// (R12) bits six/seven low during align and go phases
// (R13) revision register returns eight-bit revision code
// (R14) auto mode with spin and enable: wait, then align
// (R15) sequencer starts at phase one after reset
// (R16) align then double step, advance then double step, go
// (R17) align 2.56M cycles, advance 7.68M cycles
// (R18) doubling bit doubles both start-up intervals
// (R19) manual mode: each step bit rise advances one phase
// (R20) zero-cross output toggles on every back-emf crossing
// (R21) host times external align-and-go then sets auto
// (R22) host steps at rising rate then sets auto
// (R23) spin command starts spin-up; clearing resets and brakes
// (R24) phase reset bit returns sequencer to phase one
// (R25) six phases, wrap from last back to first
package spindle_seq_pkg;
   // ==========================================================
   // register addresses (seven-bit address field of a frame)
   localparam logic [6:0] ADDR_SPINDLE_CTRL = 7'h17;
   localparam logic [6:0] ADDR_SYSTEM_CTRL = 7'h4f;
   localparam logic [6:0] ADDR_ACTUATOR_SLEW = 7'h5f;
   localparam logic [6:0] ADDR_HEALTH_STATUS = 7'h3f;
   localparam logic [6:0] ADDR_REVISION = 7'h7f;
   // ==========================================================
   // spindle control fields
   localparam int COMMUTATION_STEP_BIT = 0;
   localparam int AUTO_SPINUP_BIT = 1;
   localparam int COMMUTATION_PHASE_RESET_BIT = 2;
   localparam int SPIN_CMD_BIT = 3;
   localparam int SPIN_OUT_EN_BIT = 4;
   // system control field
   localparam int DOUBLE_TIME_BIT = 4;
   // actuator slew control fields
   localparam int ACT_FAST_SLEW_BIT = 0;
   localparam int ACT_FORCE_HIGH_BIT = 1;
   localparam int SPIN_SLOW_SLEW_BIT = 3;
   // ==========================================================
   // reset values and widths
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [2:0] PHASE_ONE = 3'h0;
   localparam logic [2:0] PHASE_LAST = 3'h5;
   localparam int CNT_W = 24;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] ADDR_BITS = 5'h08;
   // ==========================================================
   // default interval lengths in system clock cycles
   localparam int unsigned ALIGN_CYCLES_DEF = 2560000;
   localparam int unsigned ADVANCE_CYCLES_DEF = 7680000;
   localparam int unsigned RESYNC_CYCLES_DEF = 8400000;
   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_EXT,
      ST_RESYNC,
      ST_ALIGN,
      ST_ADVANCE,
      ST_GO
   } seq_state_e;
endpackage

// file: design/pin_sync.sv
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // pin_sync

// file: design/phase_counter.sv
// six-position commutation phase counter with single and double steps
`timescale 1ns/1ns
module phase_counter
   import spindle_seq_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic clear_in,
   input wire logic step_one_in,
   input wire logic step_two_in,
   output logic [2:0] phase_out
);
   logic [2:0] plus_one_w;
   logic [2:0] plus_two_w;
   logic [2:0] phase_d;

   // wrap from the last phase back to the first
   assign plus_one_w = (phase_out == PHASE_LAST) ? PHASE_ONE : phase_out + 3'h1; // R25
   assign plus_two_w = (plus_one_w == PHASE_LAST) ? PHASE_ONE : plus_one_w + 3'h1; // R25
   assign phase_d = clear_in ? PHASE_ONE : // R24
                    step_two_in ? plus_two_w :
                    step_one_in ? plus_one_w : phase_out;

   // phase one after power-on
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         phase_out <= PHASE_ONE; // R15
      end else begin
         phase_out <= phase_d;
      end
   end
endmodule // phase_counter

// file: bench/host_model.sv
// serial register port master standing in for the host microprocessor
`timescale 1ns/1ns
module host_model (
   input wire logic clk_in,
   input wire logic line_in,
   output logic sden_out,
   output logic sclk_out,
   output logic drive_out,
   output logic data_out
);
   // clk cycles per sclk phase, kept above what the pin synchroniser needs
   localparam int HALF = 6;
   // idle levels at time zero
   initial begin
      sden_out = 1'b0;
      sclk_out = 1'b0;
      drive_out = 1'b0;
      data_out = 1'b0;
   end
   // one whole frame: control bit, seven address bits, eight data bits, lsb first
   task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] wd,
                        output logic [7:0] rdat);
      logic [15:0] bits;
      bits = {wd, addr, rd};
      rdat = 8'h00;
      sden_out <= 1'b1;
      repeat (HALF) @(posedge clk_in);
      for (int i = 0; i < 16; i++) begin
         drive_out <= !(rd && i >= 8); // host lets go of the line for read data
         data_out <= bits[i];
         repeat (HALF) @(posedge clk_in);
         if (rd && i >= 8) rdat[i-8] = line_in;
         sclk_out <= 1'b1;
         repeat (HALF) @(posedge clk_in);
         sclk_out <= 1'b0;
      end
      repeat (HALF) @(posedge clk_in);
      sden_out <= 1'b0;
      drive_out <= 1'b0;
      repeat (HALF) @(posedge clk_in);
   endtask
endmodule // host_model

// file: bench/tb_top.sv
// self-checking bench for the spindle start-up sequencer
`timescale 1ns/1ns
module tb_top;
   import spindle_seq_pkg::*;
   // ==========================================================
   // shortened intervals and an arbitrary revision value
   localparam int AL = 300;
   localparam int AD = 600;
   localparam int RS = 10;
   localparam logic [7:0] REV = 8'h3c; // arbitrary value
   logic clk_in, resetn_in, sden, sclk, hdrv, hd, dq, doe;
   logic shut, warn, lost, fault, maskn, locked, zc, chop;
   logic sp_tri, brake, act_tri, retract, standby, fast, force_hi, slow, zct;
   logic [2:0] phase;
   logic [7:0] r;
   logic [7:0] d;
   logic flip_q = 1'b0;
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   int retracts = 0;
   int t0;
   // released line shows a changing pattern, never the last value
   wire line = doe ? dq : (hdrv ? hd : flip_q);
   // clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // cycle count, line pattern and retract pulse count
   always @(posedge clk_in) begin
      flip_q <= ~flip_q;
      cyc <= cyc + 1;
      if (retract === 1'b1) retracts <= retracts + 1;
   end
   spindle_seq #(.ALIGN_CYCLES(AL), .ADVANCE_CYCLES(AD), .RESYNC_CYCLES(RS),
      .REVISION_CODE(REV)) u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .sden_in(sden),
      .sclk_in(sclk), .sdata_in(line), .sdata_out(dq), .sdata_oe_out(doe),
      .overtemp_shutdown_in(shut), .overtemp_warn_in(warn), .bemf_lost_in(lost),
      .fault_in(fault), .bemf_mask_n_in(maskn), .speed_locked_in(locked), .zero_cross_in(zc),
      .actuator_chopping_mode_in(chop), .phase_out(phase), .spindle_tristate_out(sp_tri),
      .spindle_brake_out(brake), .actuator_tristate_out(act_tri), .retract_start_out(retract),
      .standby_out(standby), .actuator_fast_slew_out(fast), .actuator_force_high_out(force_hi),
      .spindle_slow_slew_out(slow), .zero_cross_toggle_out(zct));
   host_model u_host (.clk_in(clk_in), .line_in(line), .sden_out(sden), .sclk_out(sclk),
      .drive_out(hdrv), .data_out(hd));
   // ==========================================================
   // helpers
   task automatic final_report();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      compares++;
      if (seen !== want) begin
         err_total++;
         $display("ERROR %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      logic [7:0] x;
      u_host.frame(1'b0, a, v, x);
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] q);
      u_host.frame(1'b1, a, 8'h00, q);
   endtask
   function automatic logic [7:0] stat(input logic al, input logic go);
      return {~go, ~al, locked, maskn, fault, ~lost, ~warn, ~shut};
   endfunction
   // poll for a phase until a cycle bound, then check it came no earlier than lo
   task automatic wait_phase(input logic [2:0] exp, input int lo, input int hi);
      while (phase !== exp && cyc < hi) @(posedge clk_in);
      if (phase !== exp) begin
         err_total++;
         $display("ERROR %0t phase wait ran out", $time);
         final_report();
      end
      check(8'(cyc >= lo), 8'h01);
   endtask
   task automatic zc_pulse();
      zc <= 1'b1;
      repeat (8) @(posedge clk_in);
      zc <= 1'b0;
      repeat (8) @(posedge clk_in);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'h6ad19be7));
      resetn_in = 1'b0;
      {shut, warn, lost, fault, maskn, locked, zc, chop} = 8'h08;
      repeat (5) @(posedge clk_in);
      check({phase, sp_tri, brake, zct, retract, 1'b0}, 8'h18);
      resetn_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rd(ADDR_REVISION, r);
      check(r, REV);
      rd(7'h2a, r);
      check(r, 8'h00);
      rd(ADDR_ACTUATOR_SLEW, r);
      check(r, 8'h00);
      for (int i = 0; i < 4; i++) begin
         {warn, lost, fault, maskn, locked} <= 5'($urandom);
         rd(ADDR_HEALTH_STATUS, r);
         check(r, stat(1'b0, 1'b0));
         check(8'(act_tri), 8'(lost));
      end
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 8'h0b : 8'($urandom);
         chop <= i[0];
         wr(ADDR_ACTUATOR_SLEW, d);
         check(8'({fast, force_hi, slow}), 8'({d[0], d[1] & chop, d[3]}));
      end
      {warn, lost, fault} <= 3'h0;
      wr(ADDR_SPINDLE_CTRL, 8'h04);
      wr(ADDR_SPINDLE_CTRL, 8'h18);
      check(8'({sp_tri, brake}), 8'h00);
      for (int n = 1; n < 8; n++) begin
         repeat (16 - 2 * n) @(posedge clk_in);
         wr(ADDR_SPINDLE_CTRL, 8'h19);
         wr(ADDR_SPINDLE_CTRL, 8'h18);
         check(8'(phase), 8'(n % 6));
      end
      wr(ADDR_SPINDLE_CTRL, 8'h1c);
      check(8'(phase), 8'h00);
      wr(ADDR_SPINDLE_CTRL, 8'h18);
      repeat (310) @(posedge clk_in);
      wr(ADDR_SPINDLE_CTRL, 8'h1a);
      zc_pulse();
      check(8'({phase, zct}), 8'h03);
      rd(ADDR_HEALTH_STATUS, r);
      check(r, stat(1'b0, 1'b1));
      wr(ADDR_SPINDLE_CTRL, 8'h00);
      for (int dbl = 0; dbl < 2; dbl++) begin
         wr(ADDR_SPINDLE_CTRL, 8'h04);
         wr(ADDR_SYSTEM_CTRL, 8'(dbl << 4));
         wr(ADDR_SPINDLE_CTRL, 8'h1a);
         t0 = cyc;
         rd(ADDR_HEALTH_STATUS, r);
         check(r, stat(1'b1, 1'b0));
         check(8'(phase), 8'h00);
         wait_phase(3'h2, t0 + RS + AL * (dbl + 1) - 22, t0 + RS + AL * (dbl + 1) - 8);
         t0 = cyc;
         rd(ADDR_HEALTH_STATUS, r);
         check(r, stat(1'b0, 1'b0));
         wait_phase(3'h4, t0 + AD * (dbl + 1) - 3, t0 + AD * (dbl + 1) + 3);
         rd(ADDR_HEALTH_STATUS, r);
         check(r, stat(1'b0, 1'b1));
         zc_pulse();
         zc_pulse();
         check(8'(phase), 8'h00);
         wr(ADDR_SPINDLE_CTRL, 8'h18);
         wr(ADDR_SPINDLE_CTRL, 8'h19);
         check(8'(phase), 8'h01);
         wr(ADDR_SPINDLE_CTRL, 8'h00);
      end
      wr(ADDR_SPINDLE_CTRL, 8'h18);
      lost <= 1'b1;
      repeat (4) @(posedge clk_in);
      check(8'({sp_tri, act_tri}), 8'h03);
      lost <= 1'b0;
      shut <= 1'b1;
      repeat (5) @(posedge clk_in);
      check(8'({standby, sp_tri, act_tri, retracts == 1}), 8'h0f);
      wr(ADDR_ACTUATOR_SLEW, ~d);
      check(8'({fast, slow}), 8'({d[0], d[3]}));
      rd(ADDR_HEALTH_STATUS, r);
      check(r, stat(1'b0, 1'b0));
      final_report();
   end
endmodule // tb_top
